// ---- include/rip_pkg.sv ----
// rip_pkg: constants and types shared by the reset and test-port control block
// assumes a 125 MHz core clock and a separate test clock domain
package rip_pkg;
   localparam int unsigned CORE_MHZ = 125;
   // times in microseconds, as printed defaults
   localparam int unsigned RECOVERY_US = 120;
   localparam int unsigned EE_LOCK_US = 5000;
   localparam int unsigned RECOVERY_CYC = RECOVERY_US * CORE_MHZ;
   localparam int unsigned EE_LOCK_CYC = EE_LOCK_US * CORE_MHZ;
   localparam int unsigned CNT_W = 24;

   localparam logic [7:0] TPE_OFFSET = 8'hc7;
   localparam int unsigned TPE_EN_BIT = 0;
   localparam logic [7:0] TPE_RESET = 8'h00;
   localparam logic [7:0] VM_RESET = 8'h00;
   localparam int unsigned VM_SRAM_CODE_BIT = 0;
   localparam int unsigned VM_PERIPH_BIT = 7;

   localparam int unsigned IR_W = 8;
   localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
   localparam logic [IR_W-1:0] IR_CFG_ENABLE = 8'h0c;
   localparam logic [IR_W-1:0] IR_CFG_DISABLE = 8'h0f;
   localparam logic [IR_W-1:0] IR_ERR_CLEAR = 8'h10;
   // low two bits of the config enable data: bit0 extension pins, bit1 open drain
   localparam int unsigned CFG_EXT_BIT = 0;
   localparam int unsigned CFG_OD_BIT = 1;

   typedef enum logic [15:0] {
      TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
      TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020, TS_PAU_DR = 16'h0040, TS_EX2_DR = 16'h0080,
      TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
      TS_EX1_IR = 16'h1000, TS_PAU_IR = 16'h2000, TS_EX2_IR = 16'h4000, TS_UPD_IR = 16'h8000
   } rip_tap_t;

   typedef enum logic [2:0] {
      RS_RESET = 3'h1, RS_RECOVER = 3'h2, RS_RUN = 3'h4
   } rip_rst_t;
endpackage

// ---- src/rip_tap.sv ----
// rip_tap: test access port state machine with instruction and data shift
// runs only on the test clock; command pulses leave as toggles for the core side
`timescale 1ns/1ps
`default_nettype none
module rip_tap (
   input wire logic tck_i,
   input wire logic tap_rst_n_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic cfg_en_tgl_o,
   output logic cfg_dis_tgl_o,
   output logic err_clr_tgl_o,
   output logic [1:0] cfg_opt_o
);
   import rip_pkg::*;

   typedef struct packed {
      rip_tap_t st;
      logic [IR_W-1:0] ir_sh;
      logic [IR_W-1:0] ir;
      logic [1:0] dr;
      logic [1:0] opt;
      logic en_t;
      logic dis_t;
      logic clr_t;
      logic active;
   } rip_tap_s_t;

   rip_tap_s_t s_q, s_d;
   logic tdo_q, tdo_oe_q;

   function automatic rip_tap_t rip_next(input rip_tap_t st, input logic tms);
      case (st)
         TS_RESET: rip_next = tms ? TS_RESET : TS_IDLE;
         TS_IDLE: rip_next = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: rip_next = tms ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: rip_next = tms ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR: rip_next = tms ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: rip_next = tms ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: rip_next = tms ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: rip_next = tms ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: rip_next = tms ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: rip_next = tms ? TS_RESET : TS_CAP_IR;
         TS_CAP_IR: rip_next = tms ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR: rip_next = tms ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: rip_next = tms ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: rip_next = tms ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: rip_next = tms ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: rip_next = tms ? TS_SEL_DR : TS_IDLE;
         default: rip_next = TS_RESET;
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.st = rip_next(s_q.st, tms_i);
      case (s_q.st)
         TS_CAP_IR: s_d.ir_sh = {{(IR_W-2){1'b0}}, 2'b01};
         TS_SH_IR: s_d.ir_sh = {tdi_i, s_q.ir_sh[IR_W-1:1]};
         TS_UPD_IR: s_d.ir = s_q.ir_sh;
         TS_CAP_DR: s_d.dr = s_q.opt;
         TS_SH_DR: s_d.dr = {tdi_i, s_q.dr[1]};
         TS_UPD_DR: begin
            // only configuration commands are decoded; no boundary scan
            if (s_q.ir == IR_CFG_ENABLE) begin
               s_d.opt = s_q.dr;
               s_d.active = 1'b1;
               s_d.en_t = ~s_q.en_t;
            end else if (s_q.ir == IR_CFG_DISABLE) begin
               s_d.active = 1'b0;
               s_d.dis_t = ~s_q.dis_t;
            end else if (s_q.ir == IR_ERR_CLEAR) begin
               s_d.clr_t = ~s_q.clr_t;
            end
         end
         default: ;
      endcase
      if (s_q.st == TS_RESET) begin
         s_d.ir = IR_BYPASS;
      end
   end

   always_ff @(posedge tck_i) begin
      if (!tap_rst_n_i) begin
         s_q <= '{st: TS_RESET, ir_sh: '0, ir: IR_BYPASS, dr: '0, opt: '0,
                  en_t: 1'b0, dis_t: 1'b0, clr_t: 1'b0, active: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // output data launched on the falling edge
   always_ff @(negedge tck_i) begin
      if (!tap_rst_n_i) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q <= (s_q.st == TS_SH_IR) ? s_q.ir_sh[0] : s_q.dr[0];
         tdo_oe_q <= s_q.active && (s_q.st == TS_SH_IR || s_q.st == TS_SH_DR);
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_o = tdo_oe_q;
   assign cfg_en_tgl_o = s_q.en_t;
   assign cfg_dis_tgl_o = s_q.dis_t;
   assign err_clr_tgl_o = s_q.clr_t;
   assign cfg_opt_o = s_q.opt;
endmodule
`default_nettype wire

// ---- src/rip_ctrl.sv ----
// rip_ctrl: reset sequencing, test-pin enable and status/error extension pins
// assumes nrst_i is the device reset already synchronous to core_clk_i,
// and a test clock on tck_i that may stop between frames
//
// Summary of operation
// - after reset release, wait recovery, refuse access
// - memories enter read mode at power-up
// - block eeprom write strobes five ms after power-up
// - warm reset also needs full recovery time
// - logic outputs valid after configuration loaded
// - macrocells zero at power-on, equations on warm
// - mapping bits sram-code and peripheral cleared
// - test pins enabled by OR of three
// - tdo drives only after enabling command
// - pins become general I/O when disabled
// - enable register at c7, reset clears it
// - nonvolatile bit dedicates pins permanently
// - product term can enable test pins
// - blank device enables test pins by default
// - configuration commands only, no boundary scan
// - extension pins enabled by configuration command
// - error low on flash fail until cleared
// - status high in read, low while busy
// - enabling command may select open drain
// - delivery state: config register bits zero
// - warm reset aborts test port unless dedicated
`timescale 1ns/1ps
`default_nettype none
module rip_ctrl #(
   parameter int unsigned RECOVERY_CYCLES = rip_pkg::RECOVERY_CYC,
   parameter int unsigned EE_LOCK_CYCLES = rip_pkg::EE_LOCK_CYC
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic power_on_i,
   input wire logic cfg_loaded_i,
   input wire logic nvm_test_dedicate_i,
   input wire logic blank_device_i,
   input wire logic test_pin_select_term_i,
   input wire logic [7:0] vm_config_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic access_ready_o,
   output logic [7:0] memory_mapping_reg_o,
   input wire logic ee_wr_strobe_i,
   output logic ee_wr_strobe_o,
   input wire logic flash_busy_i,
   input wire logic eeprom_busy_i,
   input wire logic flash_fail_i,
   output logic memories_read_mode_o,
   output logic macro_clear_o,
   output logic pld_out_valid_o,
   output logic test_pins_enabled_o,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic program_status_out_o,
   output logic program_status_out_oe_o,
   output logic program_error_out_o,
   output logic program_error_out_oe_o
);
   import rip_pkg::*;

   typedef struct packed {
      rip_rst_t rst;
      logic [CNT_W-1:0] rec_cnt;
      logic [CNT_W-1:0] ee_cnt;
      logic ee_lock;
      logic [7:0] tpe;
      logic [7:0] vm;
      logic [7:0] rdata;
      logic warm_seen;
      logic [2:0] en_s;
      logic [2:0] dis_s;
      logic [2:0] clr_s;
      logic [1:0] opt_m;
      logic [1:0] opt;
      logic ext_en;
      logic od;
      logic err;
      logic dis_pending;
      logic [1:0] tsel_s;
      logic [1:0] nvm_s;
      logic [1:0] trst_s;
   } rip_ctrl_s_t;

   rip_ctrl_s_t s_q, s_d;
   logic cfg_en_tgl, cfg_dis_tgl, err_clr_tgl;
   logic [1:0] cfg_opt;
   logic test_on;
   logic tap_rst_n;
   logic tap_rst_m_q, tap_rst_s_q;
   logic core_tap_rst_n;
   logic busy;

   function automatic logic rip_edge(input logic [2:0] sync);
      rip_edge = sync[2] ^ sync[1];
   endfunction

   // combined pin enable
   assign test_on = s_q.nvm_s[1] | s_q.tpe[TPE_EN_BIT] | s_q.tsel_s[1];
   // runtime-enabled port dies in reset; dedicated port keeps running
   assign core_tap_rst_n = test_on && (nrst_i || s_q.nvm_s[1]);

   // reset request to the test clock domain, released through two flops
   always_ff @(posedge tck_i or negedge core_tap_rst_n) begin
      if (!core_tap_rst_n) begin
         tap_rst_m_q <= 1'b0;
         tap_rst_s_q <= 1'b0;
      end else begin
         tap_rst_m_q <= 1'b1;
         tap_rst_s_q <= tap_rst_m_q;
      end
   end
   assign tap_rst_n = tap_rst_s_q;

   rip_tap u_tap (
      .tck_i(tck_i),
      .tap_rst_n_i(tap_rst_n),
      .tms_i(tms_i),
      .tdi_i(tdi_i),
      .tdo_o(tdo_o),
      .tdo_oe_o(tdo_oe_o),
      .cfg_en_tgl_o(cfg_en_tgl),
      .cfg_dis_tgl_o(cfg_dis_tgl),
      .err_clr_tgl_o(err_clr_tgl),
      .cfg_opt_o(cfg_opt)
   );

   assign busy = flash_busy_i | eeprom_busy_i;

   always_comb begin
      s_d = s_q;
      s_d.en_s = {s_q.en_s[1:0], cfg_en_tgl};
      s_d.dis_s = {s_q.dis_s[1:0], cfg_dis_tgl};
      s_d.clr_s = {s_q.clr_s[1:0], err_clr_tgl};
      s_d.opt_m = cfg_opt;
      s_d.opt = s_q.opt_m;
      s_d.tsel_s = {s_q.tsel_s[0], test_pin_select_term_i};
      s_d.nvm_s = {s_q.nvm_s[0], nvm_test_dedicate_i | blank_device_i};
      // test port reset seen in the core domain; toggles snap back to zero while it holds
      s_d.trst_s = {s_q.trst_s[0], tap_rst_n};
      // recovery after reset release
      case (s_q.rst)
         RS_RESET: begin
            s_d.rst = RS_RECOVER;
            s_d.rec_cnt = '0;
         end
         RS_RECOVER: begin
            if (s_q.rec_cnt >= CNT_W'(RECOVERY_CYCLES - 1)) begin
               s_d.rst = RS_RUN;
            end else begin
               s_d.rec_cnt = s_q.rec_cnt + CNT_W'(1);
            end
         end
         RS_RUN: ;
         default: s_d.rst = RS_RESET;
      endcase
      // eeprom write lockout after power-up
      if (s_q.ee_lock) begin
         if (s_q.ee_cnt >= CNT_W'(EE_LOCK_CYCLES - 1)) begin
            s_d.ee_lock = 1'b0;
         end else begin
            s_d.ee_cnt = s_q.ee_cnt + CNT_W'(1);
         end
      end
      // register read and write, refused during recovery
      if (s_q.rst == RS_RUN && reg_wr_i && reg_addr_i == TPE_OFFSET) begin
         s_d.tpe = {7'h00, reg_wdata_i[TPE_EN_BIT]};
      end
      if (s_q.rst == RS_RUN && reg_rd_i) begin
         s_d.rdata = (reg_addr_i == TPE_OFFSET) ? s_q.tpe : 8'h00;
      end
      // extension pin enable and drive type
      if (s_q.trst_s[1] && rip_edge(s_q.en_s)) begin
         s_d.ext_en = s_q.opt[CFG_EXT_BIT];
         s_d.od = s_q.opt[CFG_OD_BIT];
         s_d.dis_pending = 1'b0;
      end
      if (s_q.trst_s[1] && rip_edge(s_q.dis_s)) begin
         s_d.dis_pending = 1'b1;
      end
      // error flag: clear first so a fail in the same cycle wins
      if (s_q.trst_s[1] && rip_edge(s_q.clr_s)) begin
         s_d.err = 1'b0;
      end
      if (flash_fail_i) begin
         s_d.err = 1'b1;
      end
      if (!test_on) begin
         s_d.ext_en = 1'b0;
      end
      if (!nrst_i) begin
         s_d.rst = RS_RESET;
         s_d.rec_cnt = '0;
         s_d.tpe = TPE_RESET;
         s_d.rdata = 8'h00;
         s_d.warm_seen = 1'b1;
         // sram-as-code and peripheral bits always cleared
         s_d.vm = vm_config_i;
         s_d.vm[VM_SRAM_CODE_BIT] = 1'b0;
         s_d.vm[VM_PERIPH_BIT] = 1'b0;
         if (s_q.dis_pending) begin
            s_d.err = 1'b0;
            s_d.ext_en = 1'b0;
            s_d.dis_pending = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (power_on_i) begin
         // delivery state: configuration registers zero
         s_q <= '{rst: RS_RESET, rec_cnt: '0, ee_cnt: '0, ee_lock: 1'b1, tpe: TPE_RESET,
                  vm: VM_RESET, rdata: 8'h00, warm_seen: 1'b0, en_s: '0, dis_s: '0, clr_s: '0,
                  opt_m: '0, opt: '0, ext_en: 1'b0, od: 1'b0, err: 1'b0, dis_pending: 1'b0,
                  tsel_s: '0, nvm_s: '0, trst_s: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign access_ready_o = (s_q.rst == RS_RUN) && nrst_i;
   assign memory_mapping_reg_o = s_q.vm;
   assign ee_wr_strobe_o = ee_wr_strobe_i & ~s_q.ee_lock & access_ready_o;
   assign memories_read_mode_o = ~busy;
   // power-on clears macrocells; warm reset leaves them to their equations
   assign macro_clear_o = power_on_i;
   // valid through warm reset, after load on power-on
   assign pld_out_valid_o = cfg_loaded_i & ~power_on_i;
   assign test_pins_enabled_o = test_on;
   // status high in read mode, low while busy
   assign program_status_out_o = s_q.od ? 1'b0 : ~busy;
   assign program_status_out_oe_o = s_q.ext_en & (~s_q.od | busy);
   // error active low
   assign program_error_out_o = s_q.od ? 1'b0 : ~s_q.err;
   assign program_error_out_oe_o = s_q.ext_en & (~s_q.od | s_q.err);
endmodule
`default_nettype wire

// ---- bench/rip_tst_host.sv ----
// rip_tst_host: behavioural serial test controller driving the test link
// assumes the caller runs one frame at a time; test clock is held low between frames
`timescale 1ns/1ps
`default_nettype none
module rip_tst_host (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_oe_i
);
   logic saw_oe;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      saw_oe = 1'b0;
   end
   // one 30 ns test clock; tms and tdi change just after the falling edge
   task automatic clk1(input logic m, input logic d, input logic look);
      tms_o = m;
      tdi_o = d;
      #15;
      if (look) saw_oe = saw_oe | tdo_oe_i;
      tck_o = 1'b1;
      #15 tck_o = 1'b0;
   endtask
   task automatic reset_tap();
      repeat (5) clk1(1'b1, 1'b0, 1'b0);
      clk1(1'b0, 1'b0, 1'b0);
   endtask
   // only configuration commands are ever sent
   task automatic scan(input logic is_ir, input logic [7:0] v, input int n);
      saw_oe = 1'b0;
      clk1(1'b1, 1'b0, 1'b0);
      if (is_ir) clk1(1'b1, 1'b0, 1'b0);
      clk1(1'b0, 1'b0, 1'b0);
      clk1(1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) clk1(i == n - 1, v[i], 1'b1);
      clk1(1'b1, 1'b0, 1'b0);
      clk1(1'b0, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// ---- bench/rip_ctrl_chk.sv ----
// rip_ctrl_chk: port-level assertions on the reset and test-port control block
// assumes binding to rip_ctrl; power_on_i disables every check while high
`timescale 1ns/1ps
`default_nettype none
module rip_ctrl_chk #(
   parameter int unsigned RECOVERY_CYCLES = 20,
   parameter int unsigned EE_LOCK_CYCLES = 50
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic power_on_i,
   input wire logic cfg_loaded_i,
   input wire logic nvm_test_dedicate_i,
   input wire logic blank_device_i,
   input wire logic test_pin_select_term_i,
   input wire logic [7:0] vm_config_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic access_ready_o,
   input wire logic [7:0] memory_mapping_reg_o,
   input wire logic ee_wr_strobe_i,
   input wire logic ee_wr_strobe_o,
   input wire logic flash_busy_i,
   input wire logic eeprom_busy_i,
   input wire logic memories_read_mode_o,
   input wire logic pld_out_valid_o,
   input wire logic test_pins_enabled_o,
   input wire logic program_status_out_o,
   input wire logic program_status_out_oe_o
);
   localparam int RC = RECOVERY_CYCLES;
   localparam int EL = EE_LOCK_CYCLES;
   logic [15:0] rec_q, ee_q;
   // cycles of recovery so far, and edges since power-on fell
   always_ff @(posedge core_clk_i) begin
      rec_q <= (!nrst_i || power_on_i || access_ready_o) ? 16'h0000 : rec_q + 16'h0001;
      ee_q <= power_on_i ? 16'h0000 : ((ee_q == 16'hffff) ? ee_q : ee_q + 16'h0001);
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (power_on_i);
   property p_rst_block; !nrst_i |=> !access_ready_o; endproperty
   a_rst_block: assert property (p_rst_block) else $error("ready while in reset");
   property p_ready_time; $rose(access_ready_o) |-> rec_q >= RC - 1 && rec_q <= RC + 2; endproperty
   a_ready_time: assert property (p_ready_time) else $error("recovery length off");
   property p_ready_bound; nrst_i && !access_ready_o |-> rec_q <= RC + 2; endproperty
   a_ready_bound: assert property (p_ready_bound) else $error("recovery never ends");
   property p_ee_block; ee_wr_strobe_o |-> ee_wr_strobe_i && ee_q >= EL - 1; endproperty
   a_ee_block: assert property (p_ee_block) else $error("eeprom strobe during lockout");
   property p_vm; !nrst_i |=> memory_mapping_reg_o == ($past(vm_config_i) & 8'h7e); endproperty
   a_vm: assert property (p_vm) else $error("mapping reload wrong");
   property p_tpe_wr;
      access_ready_o && nrst_i && reg_wr_i && reg_addr_i == 8'hc7 && reg_wdata_i[0] |=> test_pins_enabled_o;
   endproperty
   a_tpe_wr: assert property (p_tpe_wr) else $error("enable write lost");
   property p_off;
      (!nrst_i && !nvm_test_dedicate_i && !blank_device_i && !test_pin_select_term_i) [*4] |-> !test_pins_enabled_o;
   endproperty
   a_off: assert property (p_off) else $error("test pins not released");
   property p_on; (nvm_test_dedicate_i || blank_device_i || test_pin_select_term_i) [*4] |-> test_pins_enabled_o;
   endproperty
   a_on: assert property (p_on) else $error("test pins not enabled");
   property p_rmode; memories_read_mode_o == !(flash_busy_i || eeprom_busy_i); endproperty
   a_rmode: assert property (p_rmode) else $error("read mode wrong");
   property p_pld; cfg_loaded_i |-> pld_out_valid_o; endproperty
   a_pld: assert property (p_pld) else $error("logic outputs invalid");
   property p_stat; program_status_out_oe_o && !program_status_out_o |-> !memories_read_mode_o; endproperty
   a_stat: assert property (p_stat) else $error("status low while idle");
   c_ready: cover property ($rose(access_ready_o));
   c_strobe: cover property (ee_wr_strobe_o);
   c_busy: cover property (program_status_out_oe_o && !program_status_out_o);
endmodule
bind rip_ctrl rip_ctrl_chk #(.RECOVERY_CYCLES(RECOVERY_CYCLES), .EE_LOCK_CYCLES(EE_LOCK_CYCLES)) chk_u (.*);
`default_nettype wire

// ---- bench/reset_and_isp_port_control_tb.sv ----
// testbench: reset sequencing, register enable, pin enables and extension pins
// assumes shortened recovery and lockout counts; the test controller model drives the link
`timescale 1ns/1ps
`default_nettype none
module reset_and_isp_port_control_tb;
   import rip_pkg::*;
   localparam int RC = 20;
   localparam int EL = 50;
   logic core_clk_i = 1'b0, nrst_i = 1'b0, power_on_i = 1'b1, cfg_loaded_i = 1'b0, nvm_test_dedicate_i = 1'b0;
   logic blank_device_i = 1'b0, test_pin_select_term_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic ee_wr_strobe_i = 1'b0, flash_busy_i = 1'b0, eeprom_busy_i = 1'b0, flash_fail_i = 1'b0;
   logic [7:0] vm_config_i = 8'hff, reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, memory_mapping_reg_o;
   logic access_ready_o, ee_wr_strobe_o, memories_read_mode_o, macro_clear_o, pld_out_valid_o, test_pins_enabled_o;
   logic tdo_o, tdo_oe_o, program_status_out_o, program_status_out_oe_o, program_error_out_o, program_error_out_oe_o;
   wire logic tck_i, tms_i, tdi_i;
   logic [31:0] lf = 32'h37e3;
   int num_errors = 0, n_checks = 0, age = 0;
   always #4 core_clk_i = ~core_clk_i;
   rip_ctrl #(.RECOVERY_CYCLES(RC), .EE_LOCK_CYCLES(EL)) dut_u (.*);
   rip_tst_host m_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_oe_i(tdo_oe_o));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      cyc(1);
      reg_wr_i = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      cyc(1);
      reg_rd_i = 1'b0;
      cyc(1);
      chk(reg_rdata_o, e);
   endtask
   // warm reset; a write is attempted at once in recovery and must be dropped
   task automatic warm(output int n);
      nrst_i = 1'b0;
      cyc(5);
      nrst_i = 1'b1;
      reg_wr(TPE_OFFSET, 8'h01);
      n = 1;
      while (access_ready_o !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic fail();
      flash_fail_i = 1'b1;
      cyc(1);
      flash_fail_i = 1'b0;
      cyc(2);
   endtask
   always @(posedge core_clk_i) begin
      #1;
      age = power_on_i ? 0 : age + 1;
      if (age < EL - 2) chk(8'(ee_wr_strobe_o), 8'h00);
      if (nrst_i && access_ready_o && age > EL + 2) chk(8'(ee_wr_strobe_o), 8'(ee_wr_strobe_i));
      lf = nx(lf);
      ee_wr_strobe_i = (power_on_i || !nrst_i) ? 1'b0 : lf[0];
   end
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end
   initial begin
      int n;
      logic [7:0] d;
      cyc(2);
      cfg_loaded_i = 1'b1;
      cyc(3); // reset pin held low through power-on
      chk(8'(macro_clear_o), 8'h01);
      chk(8'(memories_read_mode_o), 8'h01);
      power_on_i = 1'b0;
      cyc(2);
      chk(memory_mapping_reg_o, 8'h7e);
      warm(n);
      chk(8'(n), 8'(RC + 1));
      reg_rd(TPE_OFFSET, TPE_RESET);
      for (int i = 0; i < 4; i++) begin
         d = lf[15:8];
         reg_wr(TPE_OFFSET, d);
         chk(8'(test_pins_enabled_o), 8'(d[0]));
         reg_rd(TPE_OFFSET, {7'h00, d[0]});
      end
      reg_wr(TPE_OFFSET, 8'hfe);
      reg_wr(8'h10, 8'hff);
      reg_rd(8'h10, 8'h00);
      for (int i = 0; i < 3; i++) begin
         {test_pin_select_term_i, blank_device_i, nvm_test_dedicate_i} = 3'(1 << i);
         cyc(5);
         chk(8'(test_pins_enabled_o), 8'h01);
         {test_pin_select_term_i, blank_device_i, nvm_test_dedicate_i} = 3'h0;
         cyc(5);
         chk(8'(test_pins_enabled_o), 8'h00);
      end
      reg_wr(TPE_OFFSET, 8'h01);
      m_u.reset_tap();
      m_u.scan(1'b1, IR_CFG_ENABLE, 8);
      chk(8'(m_u.saw_oe), 8'h00);
      m_u.scan(1'b0, 8'h01, 2);
      chk(8'(m_u.saw_oe), 8'h00);
      m_u.scan(1'b0, 8'h01, 2);
      chk(8'(m_u.saw_oe), 8'h01);
      cyc(6);
      flash_busy_i = 1'b1;
      cyc(2);
      chk(8'({program_status_out_oe_o, program_status_out_o}), 8'h02);
      flash_busy_i = 1'b0;
      eeprom_busy_i = 1'b1;
      cyc(2);
      chk(8'({program_status_out_oe_o, program_status_out_o}), 8'h02);
      eeprom_busy_i = 1'b0;
      cyc(2);
      chk(8'({program_status_out_oe_o, program_status_out_o}), 8'h03);
      fail();
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h02);
      m_u.scan(1'b1, IR_ERR_CLEAR, 8);
      m_u.scan(1'b0, 8'h00, 2);
      cyc(6);
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h03);
      m_u.scan(1'b1, IR_CFG_ENABLE, 8);
      m_u.scan(1'b0, 8'h03, 2);
      cyc(6);
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h00);
      chk(8'({program_status_out_oe_o, program_status_out_o}), 8'h00);
      fail();
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h02);
      warm(n);
      chk(8'(n), 8'(RC + 1));
      chk(8'({test_pins_enabled_o, program_status_out_oe_o}), 8'h00);
      nvm_test_dedicate_i = 1'b1;
      cyc(4);
      m_u.reset_tap();
      m_u.scan(1'b1, IR_CFG_ENABLE, 8);
      m_u.scan(1'b0, 8'h01, 2);
      cyc(6);
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h02);
      warm(n);
      chk(8'(program_status_out_oe_o), 8'h01);
      m_u.scan(1'b1, IR_CFG_DISABLE, 8);
      m_u.scan(1'b0, 8'h00, 2);
      cyc(6);
      warm(n);
      m_u.scan(1'b1, IR_CFG_ENABLE, 8);
      m_u.scan(1'b0, 8'h01, 2);
      cyc(6);
      chk(8'({program_error_out_oe_o, program_error_out_o}), 8'h03);
      stop_test();
   end
endmodule
`default_nettype wire
